// ### src/cam_params.svh
/*
 * constants for the clock-out and address pin multiplexer: register offsets,
 * field positions, reset values and widths.
 * assumes it is included by bare name from cam_sync3, cam_pin, cam_mux and tb_top.
 */
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH

// ****************************************
// register byte offsets on the APB
// ****************************************
`define CAM_OFS_CLKSEL 12'h000
`define CAM_OFS_BUSCTL 12'h004
`define CAM_OFS_PA_FUNC 12'h008
`define CAM_OFS_PA_DIR 12'h00C
`define CAM_OFS_PA_DATA 12'h010
`define CAM_OFS_PA_PULL 12'h014
`define CAM_OFS_PE_FUNC 12'h018
`define CAM_OFS_PE_DIR 12'h01C
`define CAM_OFS_PE_DATA 12'h020
`define CAM_OFS_PE_PULL 12'h024
`define CAM_OFS_PIN_IN 12'h028

// ****************************************
// fields
// ****************************************
`define CAM_SEL_W 4
`define CAM_BUSCTL_DRV_BIT 0
`define CAM_PA_LO 8
`define CAM_PA_N 6
`define CAM_PE_LO 2
`define CAM_PE_N 2
`define CAM_PORT_W 16
`define CAM_TEST_N 4

// ****************************************
// reset values
// ****************************************
`define CAM_RST_CLKSEL 4'h0
`define CAM_RST_DRV 1'b0
`define CAM_RST_PULL 16'hFFFF

`endif

// ### src/cam_pkg.sv
/*
 * types for the clock-out and address pin multiplexer.
 * assumes nothing of its surroundings.
 */
package cam_pkg;

	// clock-out source codes; codes above postscaler are test sources
	typedef enum logic [3:0] {
		CAM_SRC_OFF,
		CAM_SRC_MASTER,
		CAM_SRC_PERIPH,
		CAM_SRC_OSC,
		CAM_SRC_PRESC,
		CAM_SRC_POSTSC,
		CAM_SRC_TEST0,
		CAM_SRC_TEST1,
		CAM_SRC_TEST2,
		CAM_SRC_TEST3
	} cam_src_e;

endpackage

// ### src/cam_sync3.sv
/*
 * three-stage input synchroniser with agreement filter.
 * assumes the input is asynchronous to pclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cam_params.svh"

module cam_sync3 (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// data
	input wire logic din,
	output logic dout
);

	logic s1;
	logic s2;
	logic s3;

	// s1 feeds only s2; a change counts once s2 and s3 agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end

endmodule // cam_sync3
`default_nettype wire

// ### src/cam_pin.sv
/*
 * one multiplexed address/port pin: chooses between the address function
 * and the general-purpose function, and resolves the idle-drive rule.
 * assumes the owning block registers the outputs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cam_params.svh"

module cam_pin (
	// selection
	input wire logic gpio_mode,
	input wire logic gpio_dir_out,
	input wire logic gpio_data,
	input wire logic pull_en,
	// address bus
	input wire logic addr_bit,
	input wire logic bus_active,
	input wire logic idle_drive_bit,
	// pad controls
	output logic next_out,
	output logic next_oe,
	output logic next_pull
);

	always_comb begin
		if (gpio_mode) begin
			next_out = gpio_data;
			next_oe = gpio_dir_out;
		end else begin
			next_out = addr_bit;
			// idle address lines float unless drive bit is set
			next_oe = bus_active | idle_drive_bit;
		end
		// pull-up only makes sense while the pin is an input
		next_pull = pull_en & ~next_oe;
	end

endmodule // cam_pin
`default_nettype wire

// ### src/cam_mux.sv
/*
 * clock output selection and low address pin multiplexing, with an APB
 * register slave.
 * assumes all internal clocks and the address bus are synchronous to
 * pclk or fed as plain levels; pad inputs are asynchronous.
 */
// Implementation choices: the APB interface to the registers and the register offsets.
// Functional notes
// [R1] drive buffered selected clock on output pin
// [R2] choices: off, master, periph, osc, pre, post
// [R3] extra select codes give test signals
// [R4] address 0-5 and controls float idle per drive
// [R5] address 6-7 obey the same drive bit
// [R6] software should set drive bit to one
// [R7] port A pins individually input or output
// [R8] port E pins individually input or output
// [R9] reset default is address bus function
// [R10] cleared port A pull bit disables pull-up
// [R11] address 0-5 map to port A bits 8-13
// [R12] port E pull bits 2,3 for address 6-7
// [R13] pins float while reset is asserted
`timescale 1ns/10ps
`default_nettype none
`include "cam_params.svh"

module cam_mux #(
	parameter int PA_N = `CAM_PA_N,
	parameter int PE_N = `CAM_PE_N
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// internal clock sources
	input wire logic master_system_clock,
	input wire logic periph_clock,
	input wire logic osc_clock,
	input wire logic presc_clock,
	input wire logic postsc_clock,
	input wire logic [`CAM_TEST_N-1:0] test_sig,
	// external memory interface
	input wire logic [7:0] emi_addr,
	input wire logic [3:0] emi_ctl,
	input wire logic emi_active,
	// pads
	output logic clock_out_pin,
	output logic clock_out_oe,
	output logic [7:0] addr_out,
	output logic [7:0] addr_oe,
	output logic [7:0] addr_pullup,
	input wire logic [7:0] addr_in,
	output logic [3:0] emi_ctl_out,
	output logic [3:0] emi_ctl_oe
);

	// ****************************************
	// registers
	// ****************************************
	cam_pkg::cam_src_e clock_out_select_reg;
	logic idle_drive_bit;
	logic [PA_N-1:0] pa_func;
	logic [PA_N-1:0] pa_dir;
	logic [PA_N-1:0] pa_data;
	logic [PA_N-1:0] port_a_pullup_enable;
	logic [PE_N-1:0] pe_func;
	logic [PE_N-1:0] pe_dir;
	logic [PE_N-1:0] pe_data;
	logic [PE_N-1:0] port_e_pullup_enable;
	logic [7:0] pin_sync;
	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic [31:0] next_prdata;
	logic next_clk;
	logic [7:0] next_out;
	logic [7:0] next_oe;
	logic [7:0] next_pull;
	logic [7:0] gpio_mode;
	logic [7:0] gpio_dir;
	logic [7:0] gpio_data;
	logic [7:0] pull_sel;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_out_select_reg <= cam_pkg::CAM_SRC_OFF;
			idle_drive_bit <= `CAM_RST_DRV; // R6
		end else if (wr_en) begin
			if (paddr == `CAM_OFS_CLKSEL) begin
				clock_out_select_reg <= cam_pkg::cam_src_e'(pwdata[`CAM_SEL_W-1:0]);
			end
			if (paddr == `CAM_OFS_BUSCTL) begin
				idle_drive_bit <= pwdata[`CAM_BUSCTL_DRV_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_func <= '0; // R9
			pe_func <= '0; // R9
			pa_dir <= '0;
			pe_dir <= '0;
			pa_data <= '0;
			pe_data <= '0;
			port_a_pullup_enable <= {PA_N{1'b1}};
			port_e_pullup_enable <= {PE_N{1'b1}};
		end else if (wr_en) begin
			case (paddr)
				`CAM_OFS_PA_FUNC: pa_func <= pwdata[`CAM_PA_LO +: PA_N]; // R11
				`CAM_OFS_PA_DIR: pa_dir <= pwdata[`CAM_PA_LO +: PA_N]; // R7
				`CAM_OFS_PA_DATA: pa_data <= pwdata[`CAM_PA_LO +: PA_N];
				`CAM_OFS_PA_PULL: port_a_pullup_enable <= pwdata[`CAM_PA_LO +: PA_N]; // R10
				`CAM_OFS_PE_FUNC: pe_func <= pwdata[`CAM_PE_LO +: PE_N]; // R12
				`CAM_OFS_PE_DIR: pe_dir <= pwdata[`CAM_PE_LO +: PE_N]; // R8
				`CAM_OFS_PE_DATA: pe_data <= pwdata[`CAM_PE_LO +: PE_N];
				`CAM_OFS_PE_PULL: port_e_pullup_enable <= pwdata[`CAM_PE_LO +: PE_N]; // R12
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	always_comb begin
		next_prdata = 32'h00000000;
		addr_hit = 1'b1;
		case (paddr)
			`CAM_OFS_CLKSEL: next_prdata[`CAM_SEL_W-1:0] = clock_out_select_reg;
			`CAM_OFS_BUSCTL: next_prdata[`CAM_BUSCTL_DRV_BIT] = idle_drive_bit;
			`CAM_OFS_PA_FUNC: next_prdata[`CAM_PA_LO +: PA_N] = pa_func;
			`CAM_OFS_PA_DIR: next_prdata[`CAM_PA_LO +: PA_N] = pa_dir;
			`CAM_OFS_PA_DATA: next_prdata[`CAM_PA_LO +: PA_N] = pa_data;
			`CAM_OFS_PA_PULL: next_prdata[`CAM_PA_LO +: PA_N] = port_a_pullup_enable;
			`CAM_OFS_PE_FUNC: next_prdata[`CAM_PE_LO +: PE_N] = pe_func;
			`CAM_OFS_PE_DIR: next_prdata[`CAM_PE_LO +: PE_N] = pe_dir;
			`CAM_OFS_PE_DATA: next_prdata[`CAM_PE_LO +: PE_N] = pe_data;
			`CAM_OFS_PE_PULL: next_prdata[`CAM_PE_LO +: PE_N] = port_e_pullup_enable;
			`CAM_OFS_PIN_IN: begin
				next_prdata[`CAM_PA_LO +: PA_N] = pin_sync[PA_N-1:0];
				next_prdata[`CAM_PE_LO +: PE_N] = pin_sync[7:PA_N];
			end
			default: addr_hit = 1'b0;
		endcase
	end

	// read data is captured in setup so access answers with zero wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			if (rd_en) begin
				prdata <= next_prdata;
			end
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_hit;
		end
	end

	// ****************************************
	// pad input synchronisers
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			cam_sync3 u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.din(addr_in[gi]),
				.dout(pin_sync[gi])
			);
		end
	endgenerate

	// ****************************************
	// clock output select
	// ****************************************
	// glitches on a source change are accepted; the pin is not a timing reference
	always_comb begin
		case (clock_out_select_reg)
			cam_pkg::CAM_SRC_MASTER: next_clk = master_system_clock; // R2
			cam_pkg::CAM_SRC_PERIPH: next_clk = periph_clock; // R2
			cam_pkg::CAM_SRC_OSC: next_clk = osc_clock; // R2
			cam_pkg::CAM_SRC_PRESC: next_clk = presc_clock; // R2
			cam_pkg::CAM_SRC_POSTSC: next_clk = postsc_clock; // R2
			cam_pkg::CAM_SRC_TEST0: next_clk = test_sig[0]; // R3
			cam_pkg::CAM_SRC_TEST1: next_clk = test_sig[1]; // R3
			cam_pkg::CAM_SRC_TEST2: next_clk = test_sig[2]; // R3
			cam_pkg::CAM_SRC_TEST3: next_clk = test_sig[3]; // R3
			default: next_clk = 1'b0;
		endcase
	end

	// registered copy: sources are sampled at pclk and thus at most half its rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_out_pin <= 1'b0;
			clock_out_oe <= 1'b0; // R13
		end else begin
			clock_out_pin <= next_clk; // R1
			clock_out_oe <= (clock_out_select_reg != cam_pkg::CAM_SRC_OFF);
		end
	end

	// ****************************************
	// address pin multiplexing
	// ****************************************
	assign gpio_mode = {pe_func, pa_func};
	assign gpio_dir = {pe_dir, pa_dir};
	assign gpio_data = {pe_data, pa_data};
	assign pull_sel = {port_e_pullup_enable, port_a_pullup_enable};

	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			cam_pin u_pin (
				.gpio_mode(gpio_mode[gi]),
				.gpio_dir_out(gpio_dir[gi]),
				.gpio_data(gpio_data[gi]),
				.pull_en(pull_sel[gi]),
				.addr_bit(emi_addr[gi]),
				.bus_active(emi_active),
				.idle_drive_bit(idle_drive_bit), // R4 R5
				.next_out(next_out[gi]),
				.next_oe(next_oe[gi]),
				.next_pull(next_pull[gi])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_out <= 8'h00;
			addr_oe <= 8'h00; // R13
			addr_pullup <= 8'h00;
			emi_ctl_out <= 4'h0;
			emi_ctl_oe <= 4'h0;
		end else begin
			addr_out <= next_out;
			addr_oe <= next_oe; // R4 R5 R7 R8
			addr_pullup <= next_pull; // R10 R12
			emi_ctl_out <= emi_ctl;
			emi_ctl_oe <= {4{emi_active | idle_drive_bit}}; // R4
		end
	end

	// ****************************************
	// checks
	// ****************************************
	clk_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
		clock_out_select_reg == cam_pkg::CAM_SRC_MASTER && $stable(clock_out_select_reg)
		|=> clock_out_pin == $past(master_system_clock))
		else $error("clock out does not follow master clock");
	clk_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
		clock_out_select_reg == cam_pkg::CAM_SRC_OFF |=> !clock_out_oe)
		else $error("clock out driven while disabled");
	clk_test_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
		clock_out_select_reg == cam_pkg::CAM_SRC_TEST0 |=> clock_out_pin == $past(test_sig[0]))
		else $error("test source not routed");
	idle_float_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
		!emi_active && !idle_drive_bit && pa_func[0] == 1'b0 |=> !addr_oe[0] && emi_ctl_oe == 4'h0)
		else $error("idle address or control lines driven");
	hi_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		idle_drive_bit && pe_func[1] == 1'b0 |=> addr_oe[7])
		else $error("address 7 floats with drive bit set");
	pa_dir_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
		pa_func[2] |=> addr_oe[2] == $past(pa_dir[2]))
		else $error("port A direction not applied");
	pe_dir_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		pe_func[0] |=> addr_oe[6] == $past(pe_dir[0]) && addr_out[6] == $past(pe_data[0]))
		else $error("port E direction or data not applied");
	reset_func_a: assert property (@(posedge pclk) // R9
		$rose(presetn) |-> pa_func == '0 && pe_func == '0)
		else $error("pins not in address mode after reset");
	pull_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
		!port_a_pullup_enable[0] |=> !addr_pullup[0])
		else $error("pull-up active with its enable cleared");
	pa_map_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
		wr_en && paddr == `CAM_OFS_PA_PULL |=> port_a_pullup_enable[0] == $past(pwdata[8]))
		else $error("port A pull bit mapping wrong");
	pe_map_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		wr_en && paddr == `CAM_OFS_PE_PULL |=> port_e_pullup_enable[0] == $past(pwdata[2]))
		else $error("port E pull bit mapping wrong");
	reset_hiz_a: assert property (@(posedge pclk) // R13
		!presetn |-> addr_oe == 8'h00 && !clock_out_oe)
		else $error("pins driven in reset");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb ready timing wrong");
	// upper field bits and second pins of each port, so a shifted slice cannot pass
	pe_pull_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		!port_e_pullup_enable[1] |=> !addr_pullup[7])
		else $error("port E pull-up active with its enable cleared");
	pa_top_map_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
		wr_en && paddr == `CAM_OFS_PA_FUNC |=> pa_func[5] == $past(pwdata[13]))
		else $error("port A upper bit mapping wrong");
	pe_top_map_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		wr_en && paddr == `CAM_OFS_PE_FUNC |=> pe_func[1] == $past(pwdata[3]))
		else $error("port E upper bit mapping wrong");
	bus_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
		emi_active && !pa_func[1] |=> addr_oe[1] && addr_out[1] == $past(emi_addr[1]))
		else $error("active bus address not driven");
	hi_float_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		!emi_active && !idle_drive_bit && !pe_func[1] |=> !addr_oe[7])
		else $error("idle address 7 driven with drive bit clear");
	pe_hi_dir_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		pe_func[1] |=> addr_oe[7] == $past(pe_dir[1]))
		else $error("port E upper direction not applied");
	pa_hi_dir_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
		pa_func[5] |=> addr_oe[5] == $past(pa_dir[5]) && addr_out[5] == $past(pa_data[5]))
		else $error("port A upper direction or data not applied");
	clk_periph_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
		clock_out_select_reg == cam_pkg::CAM_SRC_PERIPH
		|=> clock_out_oe && clock_out_pin == $past(periph_clock))
		else $error("peripheral clock not routed");
	clk_test3_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
		clock_out_select_reg == cam_pkg::CAM_SRC_TEST3 |=> clock_out_pin == $past(test_sig[3]))
		else $error("last test source not routed");
	reset_pull_a: assert property (@(posedge pclk) // R13
		!presetn |-> addr_pullup == 8'h00 && emi_ctl_oe == 4'h0)
		else $error("pull-ups or control lines active in reset");
	apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && paddr > `CAM_OFS_PIN_IN |=> pready && pslverr)
		else $error("unmapped access not flagged");

	clk_on_c: cover property (@(posedge pclk) disable iff (!presetn)
		clock_out_oe && clock_out_select_reg == cam_pkg::CAM_SRC_POSTSC);
	gpio_out_c: cover property (@(posedge pclk) disable iff (!presetn) pa_func[0] && addr_oe[0]);
	idle_drive_c: cover property (@(posedge pclk) disable iff (!presetn)
		idle_drive_bit && !emi_active && addr_oe[0]);
	bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	pe_gpio_c: cover property (@(posedge pclk) disable iff (!presetn) pe_func[0] && addr_oe[6]);

endmodule // cam_mux
`default_nettype wire

// ### verif/cam_emi_model.sv
/*
 * board and memory-bus model for the pin multiplexer: the bus side drives
 * address and control levels, and the pads resolve to one wire level each.
 * assumes the bench changes run, addr_val and the board drive at pclk edges.
 */
`timescale 1ns/10ps
`default_nettype none

module cam_emi_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control
	input wire logic run,
	input wire logic [7:0] addr_val,
	input wire logic [7:0] ext_oe,
	input wire logic [7:0] ext_val,
	// memory interface side
	output logic [7:0] emi_addr,
	output logic [3:0] emi_ctl,
	output logic emi_active,
	// pads
	input wire logic [7:0] addr_out,
	input wire logic [7:0] addr_oe,
	input wire logic [7:0] addr_pullup,
	output logic [7:0] addr_in
);
	logic [7:0] float_pat;

	// an idle bus never holds its last value, so it keeps toggling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			float_pat <= 8'h5A;
		end else begin
			float_pat <= ~float_pat;
		end
	end

	assign emi_active = run;
	assign emi_addr = run ? addr_val : float_pat;
	assign emi_ctl = run ? ~addr_val[3:0] : float_pat[3:0];

	// wire level: chip driver, then board driver, then pull-up, else floating
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (addr_oe[i])
				addr_in[i] = addr_out[i];
			else if (ext_oe[i])
				addr_in[i] = ext_val[i];
			else if (addr_pullup[i])
				addr_in[i] = 1'b1;
			else
				addr_in[i] = float_pat[i];
		end
	end
endmodule // cam_emi_model

`default_nettype wire

// ### verif/tb_top.sv
/*
 * self-checking bench for the clock-out and address pin multiplexer.
 * assumes the APB slave answers in the access cycle and pads are registered.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cam_params.svh"

module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] srcs;
	logic [7:0] emi_addr, addr_out, addr_oe, addr_pullup, addr_in, addr_val, ext_oe, ext_val;
	logic [3:0] emi_ctl, emi_ctl_out, emi_ctl_oe;
	logic emi_active, clock_out_pin, clock_out_oe, run;
	int err_total, n_compared, cyc;

	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	cam_mux i_cam_mux (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_system_clock(srcs[1]), .periph_clock(srcs[2]),
		.osc_clock(srcs[3]), .presc_clock(srcs[4]), .postsc_clock(srcs[5]),
		.test_sig(srcs[9:6]), .emi_addr(emi_addr), .emi_ctl(emi_ctl),
		.emi_active(emi_active), .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe),
		.addr_out(addr_out), .addr_oe(addr_oe), .addr_pullup(addr_pullup),
		.addr_in(addr_in), .emi_ctl_out(emi_ctl_out), .emi_ctl_oe(emi_ctl_oe));

	cam_emi_model i_cam_emi_model (.pclk(pclk), .presetn(presetn), .run(run),
		.addr_val(addr_val), .ext_oe(ext_oe), .ext_val(ext_val), .emi_addr(emi_addr),
		.emi_ctl(emi_ctl), .emi_active(emi_active), .addr_out(addr_out),
		.addr_oe(addr_oe), .addr_pullup(addr_pullup), .addr_in(addr_in));

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_sim;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// pad outputs are two registers behind the register write
	task automatic settle;
		repeat (4) @(posedge pclk);
		#1;
	endtask

	// ****************************************
	// timeout
	// ****************************************
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			end_sim;
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{presetn, psel, penable, pwrite, run} = 5'h00;
		{paddr, pwdata, srcs} = '0;
		{addr_val, ext_oe, ext_val} = '0;
		{err_total, n_compared, cyc} = '0;
		repeat (6) @(posedge pclk);
		#1;
		chk({clock_out_oe, addr_oe, addr_pullup, emi_ctl_oe}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		settle;
		rdchk(`CAM_OFS_CLKSEL, 32'h0);
		rdchk(`CAM_OFS_BUSCTL, 32'h0);
		rdchk(`CAM_OFS_PA_FUNC, 32'h0);
		rdchk(`CAM_OFS_PE_FUNC, 32'h0);
		rdchk(`CAM_OFS_PA_PULL, 32'h0000_3F00);
		rdchk(`CAM_OFS_PE_PULL, 32'h0000_000C);
		chk({addr_oe, emi_ctl_oe, addr_pullup}, 32'h0000_00FF);
		@(posedge pclk);
		run <= 1'b1;
		addr_val <= 8'hC3;
		settle;
		chk({addr_oe, addr_out, emi_ctl_oe, emi_ctl_out, addr_pullup}, 32'hFFC3_FC00);
		@(posedge pclk);
		run <= 1'b0;
		apb(1'b1, `CAM_OFS_BUSCTL, 32'h1);
		settle;
		chk({addr_oe, emi_ctl_oe}, 32'h0000_0FFF);
		apb(1'b1, `CAM_OFS_BUSCTL, 32'h0);
		// two inverse source patterns so a stuck pin or a select off by an odd code cannot match both
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge pclk);
				srcs <= p[0] ? 10'h2AA : 10'h155;
				apb(1'b1, `CAM_OFS_CLKSEL, 32'(c));
				settle;
				rdchk(`CAM_OFS_CLKSEL, 32'(c));
				chk(clock_out_oe, 32'(c != 0));
				if (c != 0)
					chk(clock_out_pin, (c < 10) ? 32'(srcs[c]) : 32'h0);
			end
		end
		// gpio mode overrides an active bus
		apb(1'b1, `CAM_OFS_PA_FUNC, 32'h0000_3F00);
		apb(1'b1, `CAM_OFS_PE_FUNC, 32'h0000_000C);
		apb(1'b1, `CAM_OFS_PA_DIR, 32'h0000_1500);
		apb(1'b1, `CAM_OFS_PE_DIR, 32'h0000_0004);
		apb(1'b1, `CAM_OFS_PA_DATA, 32'h0000_3B00);
		apb(1'b1, `CAM_OFS_PE_DATA, 32'h0000_0004);
		@(posedge pclk);
		run <= 1'b1;
		settle;
		chk({addr_oe, addr_out & addr_oe}, 32'h0000_5551);
		chk(addr_pullup, 32'h0000_00AA);
		apb(1'b1, `CAM_OFS_PA_PULL, 32'h0000_3C00);
		apb(1'b1, `CAM_OFS_PE_PULL, 32'h0000_0004);
		settle;
		chk(addr_pullup, 32'h0000_0028);
		@(posedge pclk);
		ext_oe <= 8'hAA;
		ext_val <= 8'h82;
		settle;
		settle;
		rdchk(`CAM_OFS_PIN_IN, 32'h0000_130C);
		apb(1'b0, 12'h030, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, 12'h030, 32'hFFFF_FFFF);
		chk(er, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		#1;
		chk({clock_out_oe, addr_oe, addr_pullup, emi_ctl_oe}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		settle;
		rdchk(`CAM_OFS_PA_FUNC, 32'h0);
		chk({addr_oe, addr_out}, 32'h0000_FFC3);
		end_sim;
	end
endmodule // tb_top

`default_nettype wire
